/* File: verilog/mode_regs_pkg.sv */
/*
 * constants for the mode register bank and burst column sequencer:
 * register addresses, field positions, reset values, codes.
 * assumes nothing of its surroundings.
 */
package mode_regs_pkg;
	// ==========================================================
	// register addresses
	localparam logic [7:0] ADDR_LATENCY_SELECT = 8'h02;
	localparam logic [7:0] ADDR_IO_DRIVE_CONFIG = 8'h03;
	localparam logic [7:0] ADDR_TEMP_REFRESH = 8'h04;
	// ==========================================================
	// field layout and reset values
	localparam int CODE_W = 4;
	localparam int RATE_W = 3;
	localparam int TUF_BIT = 7;
	localparam int HOT_BIT = 2;
	localparam logic [3:0] LATENCY_RESET = 4'h1;
	localparam logic [3:0] DRIVE_RESET = 4'h2;
	localparam logic [2:0] RATE_RESET = 3'h3;
	localparam logic [2:0] RATE_RESERVED = 3'h4;
	localparam logic [2:0] RATE_LOW_FAULT = 3'h0;
	localparam logic [2:0] RATE_HIGH_FAULT = 3'h7;
	// ==========================================================
	// burst length codes
	localparam logic [2:0] BURST_LEN_4 = 3'h2;
	localparam logic [2:0] BURST_LEN_8 = 3'h3;
	localparam logic [2:0] BURST_LEN_16 = 3'h4;
	localparam int COL_W = 4;
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_RUN = 3'b010,
		SEQ_LAST = 3'b100
	} seq_state_t;
endpackage : mode_regs_pkg

/* File: verilog/burst_col_seq.sv */
/*
 * burst column sequencer: emits one column offset per beat.
 * assumes start pulses only when idle and legal length codes.
 */
`timescale 1ns/1ps
module burst_col_seq
	import mode_regs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [2:0] burst_len_i,
	input wire logic wrap_select_i,
	input wire logic [mode_regs_pkg::COL_W-1:0] start_col_i,
	output logic [mode_regs_pkg::COL_W-1:0] col_q,
	output logic busy_q,
	output logic last_q
);
	seq_state_t state_q;
	logic [mode_regs_pkg::COL_W-1:0] beats_q;
	logic [mode_regs_pkg::COL_W-1:0] mask_q;

	// ==========================================================
	// wrap mask: 2 bits for bl4, 3 for bl8, 4 for bl16
	function automatic logic [COL_W-1:0] len_mask(input logic [2:0] bl);
		unique case (bl)
			BURST_LEN_8: len_mask = 4'h7;
			BURST_LEN_16: len_mask = 4'hF;
			default: len_mask = 4'h3;
		endcase
	endfunction : len_mask

	// sequencer: step the offset, wrapping inside the burst window
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= SEQ_IDLE;
			col_q <= 4'h0;
			beats_q <= 4'h0;
			mask_q <= 4'h3;
		end else begin
			unique case (state_q)
				SEQ_IDLE: begin
					if (start_i) begin
						col_q <= {start_col_i[COL_W-1:1], 1'b0};
						// no-wrap bl4 counts straight through
						mask_q <= wrap_select_i ? 4'hF
							: len_mask(burst_len_i);
						beats_q <= len_mask(burst_len_i) - 4'h1;
						state_q <= SEQ_RUN;
					end
				end
				SEQ_RUN: begin
					col_q <= (col_q & ~mask_q)
						| ((col_q + 4'h1) & mask_q);
					beats_q <= beats_q - 4'h1;
					if (beats_q == 4'h0)
						state_q <= SEQ_LAST;
				end
				SEQ_LAST: begin
					state_q <= SEQ_IDLE;
				end
			endcase
		end
	end

	// status flags from state
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			busy_q <= (state_q == SEQ_IDLE) ? start_i : (state_q == SEQ_RUN);
			last_q <= (state_q == SEQ_RUN) && (beats_q == 4'h0);
		end
	end

	step_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		state_q == SEQ_RUN |=> col_q[1:0] == $past(col_q[1:0]) + 2'h1)
		else $error("burst offset did not step");
	even_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		state_q == SEQ_IDLE && start_i |=> col_q[0] == 1'b0)
		else $error("burst started on odd column");
endmodule : burst_col_seq

/* File: verilog/mode_regs_burst_order_temp.sv */
/*
 * mode register bank (latency, drive strength, temperature status)
 * plus burst column sequencer. commands arrive already decoded
 * from the command/address path, synchronous to ref_clk_i.
 *
 */
`timescale 1ns/1ps
module mode_regs_burst_order_temp
	import mode_regs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic mr_write_i,
	input wire logic mr_read_i,
	input wire logic [7:0] mr_addr_i,
	input wire logic [7:0] mr_wdata_i,
	input wire logic [mode_regs_pkg::RATE_W-1:0] sensor_rate_i,
	input wire logic burst_start_i,
	input wire logic [2:0] burst_len_i,
	input wire logic wrap_select_i,
	input wire logic [mode_regs_pkg::COL_W-1:0] start_col_i,
	output logic [7:0] mr_rdata_o,
	output logic mr_rvalid_o,
	output logic [mode_regs_pkg::CODE_W-1:0] latency_code_o,
	output logic [mode_regs_pkg::CODE_W-1:0] drive_strength_sel_o,
	output logic hot_o,
	output logic rate_fault_o,
	output logic [mode_regs_pkg::COL_W-1:0] burst_col_o,
	output logic burst_busy_o,
	output logic burst_last_o
);
	logic rst_meta_q;
	logic rst_n_q;
	logic [RATE_W-1:0] rate_q;
	logic temp_update_flag_q;
	logic rd_temp;
	logic rate_change;
	logic wr_latency;
	logic wr_drive;

	// fault decode, shared by the status output and its check
	function automatic logic is_fault_code(input logic [RATE_W-1:0] r);
		is_fault_code = (r == RATE_LOW_FAULT) || (r == RATE_HIGH_FAULT);
	endfunction : is_fault_code

	// ==========================================================
	// reset release synchroniser
	// asserts at once, releases two edges later to avoid a runt release
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ==========================================================
	// write-only registers: latency and drive strength
	// write decode, shared by the registers and their hold checks
	assign wr_latency = mr_write_i && (mr_addr_i == ADDR_LATENCY_SELECT);
	assign wr_drive = mr_write_i && (mr_addr_i == ADDR_IO_DRIVE_CONFIG);

	// reserved codes are stored as written; keeping them out is up to
	// the controller
	always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			latency_code_o <= LATENCY_RESET;
			drive_strength_sel_o <= DRIVE_RESET;
		end else begin
			if (wr_latency)
				latency_code_o <= mr_wdata_i[CODE_W-1:0];
			if (wr_drive)
				drive_strength_sel_o <= mr_wdata_i[CODE_W-1:0];
		end
	end

	// ==========================================================
	// temperature status: sampled rate code and sticky update flag
	assign rd_temp = mr_read_i && (mr_addr_i == ADDR_TEMP_REFRESH);
	assign rate_change = (sensor_rate_i != rate_q);

	always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rate_q <= RATE_RESET;
			temp_update_flag_q <= 1'b0;
		end else begin
			rate_q <= sensor_rate_i;
			// a change in the read cycle wins over the clear
			if (rate_change)
				temp_update_flag_q <= 1'b1;
			else if (rd_temp)
				temp_update_flag_q <= 1'b0;
		end
	end

	// derived status outputs
	always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			hot_o <= 1'b0;
			rate_fault_o <= 1'b0;
		end else begin
			hot_o <= rate_q[HOT_BIT];
			rate_fault_o <= is_fault_code(rate_q);
		end
	end

	// ==========================================================
	// read port: write-only and unmapped addresses return zero
	always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mr_rdata_o <= 8'h00;
			mr_rvalid_o <= 1'b0;
		end else begin
			mr_rvalid_o <= mr_read_i;
			if (rd_temp)
				mr_rdata_o <= {temp_update_flag_q, 4'h0, rate_q};
			else
				mr_rdata_o <= 8'h00;
		end
	end

	// ==========================================================
	// burst column sequencer
	burst_col_seq u_seq (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_q),
		.start_i(burst_start_i),
		.burst_len_i(burst_len_i),
		.wrap_select_i(wrap_select_i),
		.start_col_i(start_col_i),
		.col_q(burst_col_o),
		.busy_q(burst_busy_o),
		.last_q(burst_last_o)
	);

	// ==========================================================
	// checks on the register side
	sequence rate_change_s;
		rate_change;
	endsequence
	flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		rate_change_s |=> temp_update_flag_q)
		else $error("update flag not set on change");
	flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		rd_temp && !rate_change |=> !temp_update_flag_q)
		else $error("update flag not cleared by read");
	read_data_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		rd_temp |=> mr_rdata_o[TUF_BIT] == $past(temp_update_flag_q)
		&& mr_rdata_o[2:0] == $past(rate_q))
		else $error("status read data wrong");
	lat_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		mr_write_i && mr_addr_i == ADDR_LATENCY_SELECT
		|=> latency_code_o == $past(mr_wdata_i[3:0]))
		else $error("latency code not written");
	drive_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		mr_write_i && mr_addr_i == ADDR_IO_DRIVE_CONFIG
		|=> drive_strength_sel_o == $past(mr_wdata_i[3:0]))
		else $error("drive code not written");
	hot_bit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		##1 hot_o == $past(rate_q[HOT_BIT]))
		else $error("hot flag mismatch");

	// ==========================================================
	// checks on fault flag, flag and code hold, read framing and burst status
	fault_code_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		##1 rate_fault_o == is_fault_code($past(rate_q)))
		else $error("fault flag mismatch");
	sequence flag_quiet_s;
		!rd_temp && !rate_change;
	endsequence
	flag_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		flag_quiet_s |=> $stable(temp_update_flag_q))
		else $error("update flag moved without cause");
	flag_reset_a: assert property (@(posedge ref_clk_i)
		$rose(rst_n_q) |-> !temp_update_flag_q)
		else $error("update flag set after reset");
	sequence status_read_s;
		rd_temp ##1 mr_rvalid_o;
	endsequence
	rdata_pad_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		status_read_s |-> mr_rdata_o[6:3] == 4'h0)
		else $error("status pad bits not zero");
	rvalid_echo_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		##1 mr_rvalid_o == $past(mr_read_i))
		else $error("read valid does not follow strobe");
	rdata_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		!rd_temp |=> mr_rdata_o == 8'h00)
		else $error("read data not zero off status reads");
	lat_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		!wr_latency |=> $stable(latency_code_o))
		else $error("latency code changed without write");
	drive_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		!wr_drive |=> $stable(drive_strength_sel_o))
		else $error("drive code changed without write");
	start_taken_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		burst_start_i && !burst_busy_o |=> burst_busy_o)
		else $error("burst start not taken");
	last_busy_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		burst_last_o |-> burst_busy_o)
		else $error("last beat outside burst");
	last_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
		burst_last_o |=> !burst_last_o)
		else $error("last beat flag held too long");
endmodule : mode_regs_burst_order_temp

/* File: dv/mr_ctrl_model.sv */
/* controller model: issues mode register and burst requests.
   assumes ref_clk_i from the bench; requests launch after edges. */
`timescale 1ns/1ps
module mr_ctrl_model
(
	input wire logic ref_clk_i,
	output logic mr_write_o,
	output logic mr_read_o,
	output logic [7:0] mr_addr_o,
	output logic [7:0] mr_wdata_o,
	output logic burst_start_o,
	output logic [2:0] burst_len_o,
	output logic wrap_select_o,
	output logic [3:0] start_col_o
);
	import mode_regs_pkg::*;
	// ==========================================
	// request tasks, held until the taking edge
	initial begin
		{mr_write_o, mr_read_o, burst_start_o} = 3'h0;
		{mr_addr_o, mr_wdata_o} = 16'h0;
		{burst_len_o, wrap_select_o, start_col_o} = 8'h40;
	end
	// reserved bits always written as zero
	task automatic mr_wr(input logic [7:0] a, input logic [3:0] c);
		@(posedge ref_clk_i);
		mr_write_o <= 1'b1;
		mr_addr_o <= a;
		mr_wdata_o <= {4'h0, c};
		@(posedge ref_clk_i);
		mr_write_o <= 1'b0;
		mr_addr_o <= ~a;
		mr_wdata_o <= ~{4'h0, c};
	endtask : mr_wr
	task automatic mr_rd(input logic [7:0] a);
		@(posedge ref_clk_i);
		mr_read_o <= 1'b1;
		mr_addr_o <= a;
		@(posedge ref_clk_i);
		mr_read_o <= 1'b0;
		mr_addr_o <= ~a;
	endtask : mr_rd
	// no-wrap only with bl4; callers keep starts off window edges
	task automatic burst(input logic [2:0] l, input logic nw,
		input logic [3:0] c);
		@(posedge ref_clk_i);
		burst_start_o <= 1'b1;
		burst_len_o <= l;
		wrap_select_o <= (l == BURST_LEN_4) ? nw : 1'b0;
		start_col_o <= c;
		@(posedge ref_clk_i);
		burst_start_o <= 1'b0;
		start_col_o <= ~c;
	endtask : burst
	// refresh interval scale, in quarters, taken from the reported code
	function automatic logic [7:0] refi_quarters(input logic [2:0] r);
		unique case (r)
			3'h1: refi_quarters = 8'h10;
			3'h2: refi_quarters = 8'h08;
			3'h3: refi_quarters = 8'h04;
			default: refi_quarters = 8'h01;
		endcase
	endfunction : refi_quarters
	// core row timings are stretched only for the derating code
	function automatic logic derate_core(input logic [2:0] r);
		derate_core = (r == 3'h6);
	endfunction : derate_core
endmodule : mr_ctrl_model

/* File: dv/mode_regs_burst_order_temp_bench.sv */
/* bench for the mode register bank and burst sequencer.
   assumes the controller model drives all request inputs. */
`timescale 1ns/1ps
module mode_regs_burst_order_temp_bench;
	import mode_regs_pkg::*;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [2:0] sensor_rate_i = 3'h3;
	logic mr_write_i, mr_read_i, burst_start_i, wrap_select_i;
	logic [7:0] mr_addr_i, mr_wdata_i, mr_rdata_o;
	logic [2:0] burst_len_i;
	logic [3:0] start_col_i, latency_code_o;
	logic [3:0] drive_strength_sel_o, burst_col_o;
	logic mr_rvalid_o, hot_o, rate_fault_o, burst_busy_o, burst_last_o;
	int num_errors = 0;
	int check_count = 0;
	// ==========================================
	// clock, model and design
	always #25 ref_clk_i = ~ref_clk_i;
	mr_ctrl_model mc_u (.ref_clk_i(ref_clk_i), .mr_write_o(mr_write_i),
		.mr_read_o(mr_read_i), .mr_addr_o(mr_addr_i),
		.mr_wdata_o(mr_wdata_i), .burst_start_o(burst_start_i),
		.burst_len_o(burst_len_i), .wrap_select_o(wrap_select_i),
		.start_col_o(start_col_i));
	mode_regs_burst_order_temp dut_u (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.mr_write_i(mr_write_i),
		.mr_read_i(mr_read_i),
		.mr_addr_i(mr_addr_i),
		.mr_wdata_i(mr_wdata_i),
		.sensor_rate_i(sensor_rate_i),
		.burst_start_i(burst_start_i),
		.burst_len_i(burst_len_i),
		.wrap_select_i(wrap_select_i),
		.start_col_i(start_col_i),
		.mr_rdata_o(mr_rdata_o),
		.mr_rvalid_o(mr_rvalid_o),
		.latency_code_o(latency_code_o),
		.drive_strength_sel_o(drive_strength_sel_o),
		.hot_o(hot_o),
		.rate_fault_o(rate_fault_o),
		.burst_col_o(burst_col_o),
		.burst_busy_o(burst_busy_o),
		.burst_last_o(burst_last_o)
	);
	// compare one value, count and report
	task automatic chk(input string w, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, e);
		mc_u.mr_rd(a);
		#1;
		chk("rvalid", 8'h01, {7'h0, mr_rvalid_o});
		chk("rdata", e, mr_rdata_o);
	endtask : rd_chk
	task automatic t_reset;
		chk("latency", 8'h01, {4'h0, latency_code_o});
		chk("drive", 8'h02, {4'h0, drive_strength_sel_o});
		rd_chk(ADDR_TEMP_REFRESH, 8'h03);
	endtask : t_reset
	// every legal code, then writes that must be ignored
	task automatic t_regs;
		logic [3:0] ds [5] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h7};
		for (int i = 1; i <= 6; i++) begin
			mc_u.mr_wr(ADDR_LATENCY_SELECT, 4'(i));
			@(posedge ref_clk_i) #1;
			chk("latency", 8'(i), {4'h0, latency_code_o});
		end
		foreach (ds[i]) begin
			mc_u.mr_wr(ADDR_IO_DRIVE_CONFIG, ds[i]);
			@(posedge ref_clk_i) #1;
			chk("drive", {4'h0, ds[i]}, {4'h0, drive_strength_sel_o});
		end
		mc_u.mr_wr(ADDR_TEMP_REFRESH, 4'h1);
		mc_u.mr_wr(8'h05, 4'h2);
		@(posedge ref_clk_i) #1;
		chk("latency", 8'h06, {4'h0, latency_code_o});
		chk("drive", 8'h07, {4'h0, drive_strength_sel_o});
		rd_chk(ADDR_LATENCY_SELECT, 8'h00);
		rd_chk(ADDR_TEMP_REFRESH, 8'h03);
	endtask : t_regs
	// each legal rate code, flag set then cleared by the read
	task automatic t_temp;
		logic [2:0] rc [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
		logic [7:0] rq [7] = '{8'h01, 8'h10, 8'h08, 8'h04, 8'h01, 8'h01,
			8'h01};
		foreach (rc[i]) begin
			@(posedge ref_clk_i) sensor_rate_i <= rc[i];
			repeat (3) @(posedge ref_clk_i);
			#1;
			chk("hot", {7'h0, rc[i][2]}, {7'h0, hot_o});
			chk("fault", {7'h0, rc[i] == 3'h0 || rc[i] == 3'h7},
				{7'h0, rate_fault_o});
			rd_chk(ADDR_TEMP_REFRESH, {5'h10, rc[i]});
			rd_chk(ADDR_TEMP_REFRESH, {5'h00, rc[i]});
			chk("refresh scale", rq[i],
				mc_u.refi_quarters(mr_rdata_o[2:0]));
			chk("derate", {7'h0, rc[i] == 3'h6},
				{7'h0, mc_u.derate_core(mr_rdata_o[2:0])});
		end
		// a change and change back still counts as a change
		@(posedge ref_clk_i) sensor_rate_i <= 3'h1;
		@(posedge ref_clk_i) sensor_rate_i <= 3'h7;
		repeat (3) @(posedge ref_clk_i);
		rd_chk(ADDR_TEMP_REFRESH, 8'h87);
	endtask : t_temp
	// one burst: every beat's column, busy and last
	task automatic run(input logic [2:0] l, input int n, input logic nw,
		input logic [3:0] c);
		logic [3:0] s, m;
		s = c & 4'hE;
		m = 4'(n - 1);
		mc_u.burst(l, nw, c);
		for (int i = 0; i < n; i++) begin
			#1;
			chk("col", {4'h0, nw ? s + 4'(i) : (s & ~m) | ((s + 4'(i)) & m)},
				{4'h0, burst_col_o});
			chk("busy", 8'h01, {7'h0, burst_busy_o});
			chk("last", {7'h0, i == n - 1}, {7'h0, burst_last_o});
			@(posedge ref_clk_i);
		end
		#1;
		chk("idle", 8'h00, {7'h0, burst_busy_o});
	endtask : run
	task automatic t_burst;
		for (int c = 0; c < 16; c++) begin
			run(BURST_LEN_16, 16, 1'b0, 4'(c));
			run(BURST_LEN_8, 8, 1'b0, 4'(c));
			run(BURST_LEN_4, 4, 1'b0, 4'(c));
		end
		for (int c = 0; c <= 12; c += 2)
			run(BURST_LEN_4, 4, 1'b1, 4'(c));
	endtask : t_burst
	// ==========================================
	// verdict, main sequence and watchdog
	task automatic end_of_test;
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		t_reset;
		t_regs;
		t_temp;
		t_burst;
		end_of_test;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		num_errors++;
		end_of_test;
	end
endmodule : mode_regs_burst_order_temp_bench
